//--- rtl/usb_tfa_pkg.sv
// Summary of operation
// - Toggle control reached only through subaddress 57h.
// - Bit 7 reads selected endpoint toggle.
// - Writing 1 to bit 6 forces DATA1.
// - Writing 1 to bit 5 with bit 6 at 0 forces DATA0.
// - Toggle force bits always read zero.
// - Bit 4 selects direction, 1 is IN.
// - Bits 1 to 0 select endpoint 0-3.
// - Frame count updates on every Start of Frame.
// - Subaddress 58h reads frame count bits 7-0.
// - Subaddress 59h reads frame count bits 10-8.
// - Subaddress 5Bh reads 7-bit function address.
// - Accept only tokens matching the function address.
package usb_tfa_pkg;
	localparam int EP_COUNT = 4;
	localparam logic [7:0] SA_TOGGLE = 8'h57;
	localparam logic [7:0] SA_FCOUNT_LO = 8'h58;
	localparam logic [7:0] SA_FCOUNT_HI = 8'h59;
	localparam logic [7:0] SA_FUNCTION_ADDRESS_FIELD = 8'h5B;
	localparam int TOG_VALUE_BIT = 7;
	localparam int TOG_FORCE_ONE_BIT = 6;
	localparam int TOG_FORCE_ZERO_BIT = 5;
	localparam int TOG_DIR_BIT = 4;
	localparam int TOG_EP_LSB = 0;
	localparam logic [3:0] PID_OUT = 4'h1;
	localparam logic [3:0] PID_IN = 4'h9;
	localparam logic [3:0] PID_SOF = 4'h5;
	localparam logic [3:0] PID_SETUP = 4'hD;
	localparam logic [7:0] RST_SUBADDR = 8'h00;
	localparam logic [10:0] RST_FCOUNT = 11'h000;
	localparam logic [6:0] RST_FUNCTION_ADDRESS_FIELD = 7'h00;
	localparam logic [EP_COUNT-1:0] RST_TOGGLES = '0;

	typedef struct packed {
		logic wr;
		logic rd;
		logic sel_data;
		logic [7:0] wdata;
	} cpu_req_t;

	typedef struct packed {
		logic valid;
		logic [3:0] pid;
		logic [6:0] addr;
		logic [3:0] endp;
		logic [10:0] frame;
	} token_t;

	typedef struct packed {
		logic [EP_COUNT-1:0] bits;
	} tog_state_t;

	typedef struct packed {
		logic [7:0] subaddr;
		logic dir;
		logic [1:0] ep;
		logic [10:0] fcount;
		logic [6:0] function_address_field;
		logic [7:0] rdata;
		logic accept;
		logic [3:0] accept_pid;
		logic [3:0] accept_ep;
	} tfa_state_t;
endpackage

//--- rtl/toggle_bank.sv
`timescale 1ns/1ps
`default_nettype none
module toggle_bank
	import usb_tfa_pkg::*;
#(
	parameter int N = EP_COUNT
)
(
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Software force strobes.
	input wire logic force_one_in,
	input wire logic force_zero_in,
	input wire logic [1:0] force_sel_in,
	// Transaction engine flip.
	input wire logic flip_in,
	input wire logic [1:0] flip_sel_in,
	// Toggle state.
	output logic [N-1:0] toggles_out
);
	// The select inputs are two bits wide, so only four endpoints can be served.
	if (N != EP_COUNT)
	begin
		$error("toggle_bank supports exactly four endpoints.");
	end

	tog_state_t s_r;
	tog_state_t s_nxt;

	// =========================================================
	// Toggle update; software force takes priority over a flip.
	always_comb
	begin
		s_nxt = s_r;
		if (flip_in)
			s_nxt.bits[flip_sel_in] = ~s_r.bits[flip_sel_in];
		if (force_one_in)
			s_nxt.bits[force_sel_in] = 1'b1;
		else if (force_zero_in)
			s_nxt.bits[force_sel_in] = 1'b0;
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			s_r <= '{bits: RST_TOGGLES};
		else
			s_r <= s_nxt;
	end

	assign toggles_out = s_r.bits;
endmodule
`default_nettype wire

//--- rtl/usb_toggle_frame_address.sv
`timescale 1ns/1ps
`default_nettype none
module usb_toggle_frame_address
	import usb_tfa_pkg::*;
(
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Software access: subaddress select or subdata register.
	input wire cpu_req_t cpu_in,
	output logic [7:0] rdata_out,
	// Decoded tokens from the packet receiver.
	input wire token_t token_in,
	// Function address assignment and bus reset.
	input wire logic addr_load_in,
	input wire logic [6:0] addr_value_in,
	input wire logic bus_reset_in,
	// Toggle flip from the transaction engine.
	input wire logic tog_flip_in,
	input wire logic tog_flip_dir_in,
	input wire logic [1:0] tog_flip_ep_in,
	// Token acceptance and state to the transaction engine.
	output logic tok_accept_out,
	output logic [3:0] tok_accept_pid_out,
	output logic [3:0] tok_accept_ep_out,
	output logic [EP_COUNT-1:0] tog_in_out,
	output logic [EP_COUNT-1:0] tog_out_out,
	output logic [10:0] frame_count_out,
	output logic [6:0] func_addr_out
);
	tfa_state_t s_r;
	tfa_state_t s_nxt;
	logic data_wr;
	logic data_rd;
	logic tog_wr;
	logic cur_tog;
	logic sof_seen;
	logic [7:0] rd_mux;

	// =========================================================
	// Access decode.
	assign data_wr = cpu_in.wr && cpu_in.sel_data;
	assign data_rd = cpu_in.rd && cpu_in.sel_data;
	assign tog_wr = data_wr && (s_r.subaddr == SA_TOGGLE);
	assign cur_tog = s_r.dir ? tog_in_out[s_r.ep] : tog_out_out[s_r.ep];
	assign sof_seen = token_in.valid && (token_in.pid == PID_SOF);

	// =========================================================
	// Toggle banks for IN and OUT endpoints.
	toggle_bank #(.N(EP_COUNT)) u_in_bank (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.force_one_in(tog_wr && cpu_in.wdata[TOG_DIR_BIT] && cpu_in.wdata[TOG_FORCE_ONE_BIT]),
		.force_zero_in(tog_wr && cpu_in.wdata[TOG_DIR_BIT] && cpu_in.wdata[TOG_FORCE_ZERO_BIT]),
		.force_sel_in(cpu_in.wdata[TOG_EP_LSB +: 2]),
		.flip_in(tog_flip_in && tog_flip_dir_in),
		.flip_sel_in(tog_flip_ep_in),
		.toggles_out(tog_in_out)
	);

	toggle_bank #(.N(EP_COUNT)) u_out_bank (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.force_one_in(tog_wr && !cpu_in.wdata[TOG_DIR_BIT] && cpu_in.wdata[TOG_FORCE_ONE_BIT]),
		.force_zero_in(tog_wr && !cpu_in.wdata[TOG_DIR_BIT] && cpu_in.wdata[TOG_FORCE_ZERO_BIT]),
		.force_sel_in(cpu_in.wdata[TOG_EP_LSB +: 2]),
		.flip_in(tog_flip_in && !tog_flip_dir_in),
		.flip_sel_in(tog_flip_ep_in),
		.toggles_out(tog_out_out)
	);

	// =========================================================
	// Read data selection.
	always_comb
	begin
		rd_mux = 8'h00;
		if (!cpu_in.sel_data)
			rd_mux = s_r.subaddr;
		else
		begin
			unique case (s_r.subaddr)
				SA_TOGGLE:
					rd_mux = {cur_tog, 2'b00, s_r.dir, 2'b00, s_r.ep};
				SA_FCOUNT_LO:
					rd_mux = s_r.fcount[7:0];
				SA_FCOUNT_HI:
					rd_mux = {5'h00, s_r.fcount[10:8]};
				SA_FUNCTION_ADDRESS_FIELD:
					rd_mux = {1'b0, s_r.function_address_field};
				default:
					rd_mux = 8'h00;
			endcase
		end
	end

	// =========================================================
	// State update.
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.accept = 1'b0;
		if (cpu_in.wr && !cpu_in.sel_data)
			s_nxt.subaddr = cpu_in.wdata;
		if (tog_wr)
		begin
			s_nxt.dir = cpu_in.wdata[TOG_DIR_BIT];
			s_nxt.ep = cpu_in.wdata[TOG_EP_LSB +: 2];
		end
		if (cpu_in.rd)
			s_nxt.rdata = rd_mux;
		if (sof_seen)
			s_nxt.fcount = token_in.frame;
		if (bus_reset_in)
			s_nxt.function_address_field = RST_FUNCTION_ADDRESS_FIELD;
		else if (addr_load_in)
			s_nxt.function_address_field = addr_value_in;
		if (token_in.valid && !sof_seen && (token_in.addr == s_r.function_address_field))
		begin
			s_nxt.accept = 1'b1;
			s_nxt.accept_pid = token_in.pid;
			s_nxt.accept_ep = token_in.endp;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			s_r <= '{subaddr: RST_SUBADDR, dir: 1'b0, ep: 2'b00, fcount: RST_FCOUNT,
				function_address_field: RST_FUNCTION_ADDRESS_FIELD, rdata: 8'h00, accept: 1'b0, accept_pid: 4'h0,
				accept_ep: 4'h0};
		end
		else
			s_r <= s_nxt;
	end

	assign rdata_out = s_r.rdata;
	assign tok_accept_out = s_r.accept;
	assign tok_accept_pid_out = s_r.accept_pid;
	assign tok_accept_ep_out = s_r.accept_ep;
	assign frame_count_out = s_r.fcount;
	assign func_addr_out = s_r.function_address_field;

	// =========================================================
	// Assertions.
	property p_indirect;
		@(posedge clk_in) disable iff (!rst_n_in)
		(data_wr && s_r.subaddr != SA_TOGGLE) |=> $stable(s_r.dir) && $stable(s_r.ep);
	endproperty
	a_indirect: assert property (p_indirect) else $error("Toggle fields changed off 57h.");

	property p_tog_read;
		@(posedge clk_in) disable iff (!rst_n_in)
		(data_rd && s_r.subaddr == SA_TOGGLE) |=> rdata_out[7] == $past(cur_tog);
	endproperty
	a_tog_read: assert property (p_tog_read) else $error("Toggle value read wrong.");

	property p_force_one;
		@(posedge clk_in) disable iff (!rst_n_in)
		(tog_wr && cpu_in.wdata[TOG_FORCE_ONE_BIT]) |=> cur_tog ##1 1'b1;
	endproperty
	a_force_one: assert property (p_force_one) else $error("Force to DATA1 failed.");

	property p_force_zero;
		@(posedge clk_in) disable iff (!rst_n_in)
		(tog_wr && cpu_in.wdata[6:5] == 2'b01) |=> !cur_tog;
	endproperty
	a_force_zero: assert property (p_force_zero) else $error("Force to DATA0 failed.");

	property p_strobe_zero;
		@(posedge clk_in) disable iff (!rst_n_in)
		(data_rd && s_r.subaddr == SA_TOGGLE) |=> rdata_out[6:5] == 2'b00 && rdata_out[3:2] == 2'b00;
	endproperty
	a_strobe_zero: assert property (p_strobe_zero) else $error("Strobe bits read nonzero.");

	property p_select;
		@(posedge clk_in) disable iff (!rst_n_in)
		tog_wr |=> s_r.dir == $past(cpu_in.wdata[4]) && s_r.ep == $past(cpu_in.wdata[1:0]);
	endproperty
	a_select: assert property (p_select) else $error("Endpoint select not stored.");

	property p_frame;
		@(posedge clk_in) disable iff (!rst_n_in)
		sof_seen |=> frame_count_out == $past(token_in.frame);
	endproperty
	a_frame: assert property (p_frame) else $error("Frame count not loaded.");

	property p_fc_lo;
		@(posedge clk_in) disable iff (!rst_n_in)
		(data_rd && s_r.subaddr == SA_FCOUNT_LO) |=> rdata_out == $past(s_r.fcount[7:0]);
	endproperty
	a_fc_lo: assert property (p_fc_lo) else $error("Frame count low read wrong.");

	property p_fc_hi;
		@(posedge clk_in) disable iff (!rst_n_in)
		(data_rd && s_r.subaddr == SA_FCOUNT_HI) |=> rdata_out == {5'h00, $past(s_r.fcount[10:8])};
	endproperty
	a_fc_hi: assert property (p_fc_hi) else $error("Frame count high read wrong.");

	property p_function_address_field;
		@(posedge clk_in) disable iff (!rst_n_in)
		(data_rd && s_r.subaddr == SA_FUNCTION_ADDRESS_FIELD) |=> rdata_out == {1'b0, $past(s_r.function_address_field)};
	endproperty
	a_function_address_field: assert property (p_function_address_field) else $error("Function address read wrong.");

	property p_match;
		@(posedge clk_in) disable iff (!rst_n_in)
		tok_accept_out |-> $past(token_in.valid) && $past(token_in.addr) == $past(s_r.function_address_field);
	endproperty
	a_match: assert property (p_match) else $error("Token accepted for other address.");

	property p_sof_quiet;
		@(posedge clk_in) disable iff (!rst_n_in)
		sof_seen |=> !tok_accept_out;
	endproperty
	a_sof_quiet: assert property (p_sof_quiet) else $error("Start of Frame raised an accept.");

	c_force: cover property (@(posedge clk_in) disable iff (!rst_n_in)
		tog_wr && cpu_in.wdata[TOG_FORCE_ONE_BIT]);
	c_sof: cover property (@(posedge clk_in) disable iff (!rst_n_in) sof_seen);
	c_accept: cover property (@(posedge clk_in) disable iff (!rst_n_in) tok_accept_out);
	c_flip: cover property (@(posedge clk_in) disable iff (!rst_n_in) tog_flip_in);
endmodule
`default_nettype wire

//--- bench/usb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module usb_host_model
	import usb_tfa_pkg::*;
(
	// Clock.
	input wire logic clk_in,
	// Token link.
	output token_t token_out
);
	// ========
	// Token sender.
	// One token is shown for one cycle, then the idle fields are scrambled.
	task automatic send(input logic [3:0] pid, input logic [6:0] addr, input logic [3:0] endp,
		input logic [10:0] frame);
		@(negedge clk_in);
		token_out = '{1'b1, pid, addr, endp, frame};
		@(negedge clk_in);
		token_out = {1'b0, ~token_out[25:0]};
	endtask
	initial
	begin
		token_out = '0;
	end
endmodule
`default_nettype wire

//--- bench/usb_toggle_frame_address_test.sv
`timescale 1ns/1ps
`default_nettype none
module usb_toggle_frame_address_test
	import usb_tfa_pkg::*;
;
	logic clk_in, rst_n_in, addr_load_in, bus_reset_in;
	logic tog_flip_in, tog_flip_dir_in, tok_accept_out, hit;
	cpu_req_t cpu_in;
	wire token_t token_in;
	logic [7:0] rdata_out;
	logic [6:0] addr_value_in, func_addr_out, fa;
	logic [1:0] tog_flip_ep_in;
	logic [3:0] tok_accept_pid_out, tok_accept_ep_out, tog_in_out, tog_out_out, m_in, m_out, pid;
	logic [10:0] frame_count_out, fc;
	logic [31:0] seed, r;
	int error_cnt, samples_checked;
	localparam logic [3:0] PIDS [4] = '{PID_OUT, PID_IN, PID_SETUP, PID_SOF};
	localparam logic [7:0] SAS [5] = '{SA_TOGGLE, SA_FCOUNT_LO, SA_FCOUNT_HI, SA_FUNCTION_ADDRESS_FIELD, 8'h5A};
	usb_toggle_frame_address dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .cpu_in(cpu_in),
		.rdata_out(rdata_out), .token_in(token_in), .addr_load_in(addr_load_in),
		.addr_value_in(addr_value_in), .bus_reset_in(bus_reset_in), .tog_flip_in(tog_flip_in),
		.tog_flip_dir_in(tog_flip_dir_in), .tog_flip_ep_in(tog_flip_ep_in),
		.tok_accept_out(tok_accept_out), .tok_accept_pid_out(tok_accept_pid_out),
		.tok_accept_ep_out(tok_accept_ep_out), .tog_in_out(tog_in_out), .tog_out_out(tog_out_out),
		.frame_count_out(frame_count_out), .func_addr_out(func_addr_out));
	usb_host_model host (.clk_in(clk_in), .token_out(token_in));
	// ========
	// Helpers.
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic exp_tog(input logic dir, input logic [1:0] ep);
		return dir ? m_in[ep] : m_out[ep];
	endfunction
	task automatic chk(input string nm, input logic [10:0] exp, input logic [10:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic acc(input logic w, input logic rd, input logic s, input logic [7:0] d);
		@(negedge clk_in);
		cpu_in = '{w, rd, s, d};
	endtask
	task automatic rd_chk(input string nm, input logic [7:0] sa, input logic [7:0] exp);
		acc(1'b1, 1'b0, 1'b0, sa);
		acc(1'b0, 1'b1, 1'b1, 8'h00);
		acc(1'b0, 1'b0, 1'b0, 8'h00);
		chk(nm, 11'(exp), 11'(rdata_out));
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ========
	// Clock, watchdog and main sequence.
	initial
	begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	initial
	begin
		repeat (6000) @(posedge clk_in);
		error_cnt++;
		end_of_test();
	end
	initial
	begin
		seed = 32'h00000055;
		cpu_in = '0;
		{rst_n_in, addr_load_in, bus_reset_in, tog_flip_in, tog_flip_dir_in} = '0;
		{addr_value_in, tog_flip_ep_in, m_in, m_out, fc} = '0;
		error_cnt = 0;
		samples_checked = 0;
		repeat (4) @(posedge clk_in);
		@(negedge clk_in);
		rst_n_in = 1'b1;
		foreach (SAS[i]) rd_chk("reset value", SAS[i], 8'h00);
		acc(1'b1, 1'b0, 1'b0, 8'h5A);
		acc(1'b0, 1'b1, 1'b0, 8'h00);
		acc(1'b0, 1'b0, 1'b0, 8'h00);
		chk("subaddress readback", 11'h05A, 11'(rdata_out));
		for (int i = 0; i < 48; i++)
		begin
			r = rnd();
			acc(1'b1, 1'b0, 1'b0, SA_TOGGLE);
			acc(1'b1, 1'b0, 1'b1, {r[7:4], 2'b00, r[1:0]});
			if (r[6] || r[5])
				if (r[4]) m_in[r[1:0]] = r[6]; else m_out[r[1:0]] = r[6];
			rd_chk("toggle", SA_TOGGLE, {exp_tog(r[4], r[1:0]), 2'b00, r[4], 2'b00, r[1:0]});
			chk("in toggles", 11'(m_in), 11'(tog_in_out));
			chk("out toggles", 11'(m_out), 11'(tog_out_out));
			@(negedge clk_in);
			{tog_flip_in, tog_flip_dir_in, tog_flip_ep_in} = r[11:8];
			if (r[11])
				if (r[10]) m_in[r[9:8]] = ~m_in[r[9:8]]; else m_out[r[9:8]] = ~m_out[r[9:8]];
			@(negedge clk_in);
			tog_flip_in = 1'b0;
		end
		chk("in toggles after flip", 11'(m_in), 11'(tog_in_out));
		chk("out toggles after flip", 11'(m_out), 11'(tog_out_out));
		r = rnd();
		fa = r[6:0];
		@(negedge clk_in);
		{addr_load_in, addr_value_in} = {1'b1, fa};
		@(negedge clk_in);
		addr_load_in = 1'b0;
		chk("function address port", 11'(fa), 11'(func_addr_out));
		acc(1'b1, 1'b0, 1'b0, SA_FUNCTION_ADDRESS_FIELD);
		acc(1'b1, 1'b0, 1'b1, ~{1'b0, fa});
		rd_chk("function address", SA_FUNCTION_ADDRESS_FIELD, {1'b0, fa});
		for (int i = 0; i < 32; i++)
		begin
			r = rnd();
			pid = PIDS[r[1:0]];
			hit = r[2] && pid != PID_SOF;
			host.send(pid, r[2] ? fa : fa ^ {r[9:4], 1'b1}, r[13:10], r[24:14]);
			if (pid == PID_SOF) fc = r[24:14];
			chk("accept", 11'(hit), 11'(tok_accept_out));
			chk("frame count", fc, frame_count_out);
			if (hit) chk("accept pid and ep", {3'h0, pid, r[13:10]}, {3'h0, tok_accept_pid_out, tok_accept_ep_out});
			if (pid == PID_SOF) rd_chk("frame low", SA_FCOUNT_LO, fc[7:0]);
			if (pid == PID_SOF) rd_chk("frame high", SA_FCOUNT_HI, {5'h00, fc[10:8]});
		end
		@(negedge clk_in);
		{bus_reset_in, addr_load_in} = 2'b11;
		@(negedge clk_in);
		{bus_reset_in, addr_load_in} = 2'b00;
		rd_chk("function address cleared", SA_FUNCTION_ADDRESS_FIELD, 8'h00);
		chk("function address port cleared", 11'h000, 11'(func_addr_out));
		host.send(PID_IN, fa | 7'h01, 4'h1, 11'h000);
		chk("old address refused", 11'h000, 11'(tok_accept_out));
		host.send(PID_OUT, 7'h00, 4'h3, 11'h000);
		chk("zero address taken", 11'h001, 11'(tok_accept_out));
		end_of_test();
	end
endmodule
`default_nettype wire
